// ==== dwdt_map.vh ====
// dwdt_map.vh: constants for the dual watchdog block
// assumes a 250 MHz clk; included by the design and the bench
`ifndef DWDT_MAP_VH
`define DWDT_MAP_VH
// tick base: 250 clk cycles make one microsecond
`define DWDT_TICK_CYC       8'hfa
// timeout range in microsecond ticks, 1 us up to 32 minutes
`define DWDT_MIN_US         31'h0000001
`define DWDT_MAX_US         31'h7270e000
`define DWDT_CNT_W          31
// reset defaults: eight and sixteen seconds in ticks
`define DWDT_DEF0_US        31'h07a1200
`define DWDT_DEF1_US        31'h0f42400
// command port codes
`define DWDT_KEY            32'h0000a5c3
`define DWDT_CMD_LOAD       2'h1
`define DWDT_CMD_RELOAD     2'h2
`define DWDT_CMD_DISABLE    2'h3
`endif

// ==== dwdt_top.v ====
// dwdt_top.v: two independent down-counting watchdogs, no bus
// assumes commands come from logic on clk; resets from pins are raw
//
// Operation
// - two identical watchdogs with separate state
// - enabled count decrements, stops at zero
// - period programmable one microsecond to 32 minutes
// - zero count asserts timeout output
// - first timeout drives interrupt controller input
// - second timeout drives auxiliary reset, reset-out
// - first timer resets enabled, eight seconds
// - second timer resets enabled, sixteen seconds
// - load new value or restart last loaded
// - changes need a two-step access sequence
// - reset-out also from power-up, debug, software
`timescale 1ns/10ps
`include "dwdt_map.vh"
module dwdt_top (
  input  wire        clk,
  input  wire        resetn,
  input  wire        cmd_valid,
  input  wire        cmd_sel,
  input  wire [31:0] cmd_wdata,
  input  wire [1:0]  cmd_code,
  input  wire        power_up_rst,
  input  wire        debug_rst_n,
  input  wire        sw_module_rst,
  output reg         interrupt_watchdog_irq,
  output reg         auxiliary_reset_in,
  output reg         module_reset_out_n,
  output reg  [1:0]  wd_enabled,
  output reg  [1:0]  wd_expired
);
  localparam [`DWDT_CNT_W-1:0] DEF0 = `DWDT_DEF0_US;
  localparam [`DWDT_CNT_W-1:0] DEF1 = `DWDT_DEF1_US;
  localparam [`DWDT_CNT_W-1:0] CMAX = `DWDT_MAX_US;
  localparam [`DWDT_CNT_W-1:0] CMIN = `DWDT_MIN_US;
  localparam [7:0] TICK_LAST = `DWDT_TICK_CYC - 8'h01;

  // clamp a requested period into the legal range
  function [`DWDT_CNT_W-1:0] dwdt_clamp;
    input [31:0] v;
    begin
      if (v > {1'b0, CMAX})
        dwdt_clamp = CMAX;
      else if (v < {1'b0, CMIN})
        dwdt_clamp = CMIN;
      else
        dwdt_clamp = v[`DWDT_CNT_W-1:0];
    end
  endfunction

  // raw pin resets pass two flops before use
  reg [1:0] pu_s_q;
  reg [1:0] dbg_s_q;
  always @(posedge clk) begin
    if (!resetn) begin
      pu_s_q  <= 2'h0;
      dbg_s_q <= 2'h3;
    end else begin
      pu_s_q  <= {pu_s_q[0], power_up_rst};
      dbg_s_q <= {dbg_s_q[0], debug_rst_n};
    end
  end

  // shared microsecond tick; both timers see it equally
  reg [7:0] tick_cnt_q;
  reg       tick_q;
  always @(posedge clk) begin
    if (!resetn) begin
      tick_cnt_q <= 8'h00;
      tick_q     <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      if (tick_cnt_q == TICK_LAST)
        tick_cnt_q <= 8'h00;
      else
        tick_cnt_q <= tick_cnt_q + 8'h01;
    end
  end

  // zero test shared by the decrement stop and the expiry flags
  function dwdt_is_zero;
    input [`DWDT_CNT_W-1:0] c;
    begin
      dwdt_is_zero = (c == {`DWDT_CNT_W{1'b0}});
    end
  endfunction

  // arm bit next value; a second write always disarms
  function dwdt_arm_next;
    input        hit;
    input        armed;
    input [31:0] wdata;
    begin
      dwdt_arm_next = armed;
      if (hit) begin
        if (armed)
          dwdt_arm_next = 1'b0;
        else
          dwdt_arm_next = (wdata == `DWDT_KEY);
      end
    end
  endfunction

  // enable next value; load and reload also re-enable
  function dwdt_en_next;
    input       hit;
    input       armed;
    input [1:0] code;
    input       en;
    begin
      dwdt_en_next = en;
      if (hit && armed) begin
        case (code)
          `DWDT_CMD_LOAD:    dwdt_en_next = 1'b1;
          `DWDT_CMD_RELOAD:  dwdt_en_next = 1'b1;
          `DWDT_CMD_DISABLE: dwdt_en_next = 1'b0;
          default:           dwdt_en_next = en;
        endcase
      end
    end
  endfunction

  // last loaded value; only a load replaces it
  function [`DWDT_CNT_W-1:0] dwdt_ldv_next;
    input                   hit;
    input                   armed;
    input [1:0]             code;
    input [31:0]            wdata;
    input [`DWDT_CNT_W-1:0] ldv;
    begin
      dwdt_ldv_next = ldv;
      if (hit && armed && (code == `DWDT_CMD_LOAD))
        dwdt_ldv_next = dwdt_clamp(wdata);
    end
  endfunction

  // count next value; any write to this timer skips the tick,
  // which costs at most one microsecond of slack per write
  function [`DWDT_CNT_W-1:0] dwdt_cnt_next;
    input                   hit;
    input                   armed;
    input [1:0]             code;
    input [31:0]            wdata;
    input                   en;
    input                   tick;
    input [`DWDT_CNT_W-1:0] cnt;
    input [`DWDT_CNT_W-1:0] ldv;
    begin
      dwdt_cnt_next = cnt;
      if (hit) begin
        if (armed && (code == `DWDT_CMD_LOAD))
          dwdt_cnt_next = dwdt_clamp(wdata);
        else if (armed && (code == `DWDT_CMD_RELOAD))
          dwdt_cnt_next = ldv;
      end else if (en && tick && !dwdt_is_zero(cnt)) begin
        dwdt_cnt_next = cnt - 1'b1;
      end
    end
  endfunction

  // per-timer state: count, last loaded value, enable, arm
  reg  [`DWDT_CNT_W-1:0] cnt_q   [0:1];
  reg  [`DWDT_CNT_W-1:0] ldv_q   [0:1];
  reg  [1:0]             en_q;
  reg  [1:0]             armed_q;

  // write strobe split per timer; one timer is hit a cycle
  wire [1:0]             hit;
  assign hit[0] = cmd_valid & ~cmd_sel;
  assign hit[1] = cmd_valid &  cmd_sel;

  // next state; same functions for both keep the timers alike
  wire [`DWDT_CNT_W-1:0] cnt0_d;
  wire [`DWDT_CNT_W-1:0] cnt1_d;
  wire [`DWDT_CNT_W-1:0] ldv0_d;
  wire [`DWDT_CNT_W-1:0] ldv1_d;
  wire [1:0]             en_d;
  wire [1:0]             armed_d;

  // first timer, toward the interrupt controller
  assign cnt0_d = dwdt_cnt_next(hit[0], armed_q[0], cmd_code, cmd_wdata,
                                en_q[0], tick_q, cnt_q[0], ldv_q[0]);
  assign ldv0_d = dwdt_ldv_next(hit[0], armed_q[0], cmd_code, cmd_wdata,
                                ldv_q[0]);
  assign en_d[0] = dwdt_en_next(hit[0], armed_q[0], cmd_code, en_q[0]);
  assign armed_d[0] = dwdt_arm_next(hit[0], armed_q[0], cmd_wdata);

  // second timer, toward the auxiliary reset
  assign cnt1_d = dwdt_cnt_next(hit[1], armed_q[1], cmd_code, cmd_wdata,
                                en_q[1], tick_q, cnt_q[1], ldv_q[1]);
  assign ldv1_d = dwdt_ldv_next(hit[1], armed_q[1], cmd_code, cmd_wdata,
                                ldv_q[1]);
  assign en_d[1] = dwdt_en_next(hit[1], armed_q[1], cmd_code, en_q[1]);
  assign armed_d[1] = dwdt_arm_next(hit[1], armed_q[1], cmd_wdata);

  // state registers; reset loads the default periods, enabled
  always @(posedge clk) begin
    if (!resetn) begin
      cnt_q[0] <= DEF0;
      ldv_q[0] <= DEF0;
      cnt_q[1] <= DEF1;
      ldv_q[1] <= DEF1;
      en_q     <= 2'h3;
      armed_q  <= 2'h0;
    end else begin
      cnt_q[0] <= cnt0_d;
      ldv_q[0] <= ldv0_d;
      cnt_q[1] <= cnt1_d;
      ldv_q[1] <= ldv1_d;
      en_q     <= en_d;
      armed_q  <= armed_d;
    end
  end

  // expiry flags; disabled timers never flag
  wire [1:0]             exp_d;
  assign exp_d[0] = en_q[0] & dwdt_is_zero(cnt_q[0]);
  assign exp_d[1] = en_q[1] & dwdt_is_zero(cnt_q[1]);

  // reset-out request: second timer plus the other module resets
  wire                   rst_out_d;
  assign rst_out_d = exp_d[1] | pu_s_q[1] | ~dbg_s_q[1] | sw_module_rst;

  // registered outputs toward interrupt and reset logic
  always @(posedge clk) begin
    if (!resetn) begin
      interrupt_watchdog_irq <= 1'b0;
      auxiliary_reset_in     <= 1'b0;
      module_reset_out_n     <= 1'b1;
      wd_enabled             <= 2'h3;
      wd_expired             <= 2'h0;
    end else begin
      interrupt_watchdog_irq <= exp_d[0];
      auxiliary_reset_in     <= exp_d[1];
      // aux and reset-out share an edge: both come from exp_d[1]
      module_reset_out_n     <= ~rst_out_d;
      wd_enabled             <= en_q;
      wd_expired             <= exp_d;
    end
  end
endmodule

// ==== dwdt_top_sva.sv ====
// checker: watchdog outputs tied to their causes
// assumes bind onto dwdt_top, one clk domain
`timescale 1ns/10ps
module dwdt_chk (
  input wire       clk,
  input wire       resetn,
  input wire       cmd_valid,
  input wire       cmd_sel,
  input wire       interrupt_watchdog_irq,
  input wire       auxiliary_reset_in,
  input wire       module_reset_out_n,
  input wire [1:0] wd_enabled,
  input wire [1:0] wd_expired
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  irq_cause_a: assert property (interrupt_watchdog_irq |->
    wd_expired[0] && wd_enabled[0]) else $error("stray irq");
  aux_cause_a: assert property (auxiliary_reset_in |->
    wd_expired[1]) else $error("stray aux reset");
  reset_out_a: assert property (auxiliary_reset_in |->
    !module_reset_out_n) else $error("reset out missing");
  reset_defaults_a: assert property ($rose(resetn) |->
    wd_enabled == 2'h3 && wd_expired == 2'h0) else $error("bad defaults");
  irq_rise_a: assert property ($rose(wd_expired[0]) && wd_enabled[0]
    |-> ##[0:1] interrupt_watchdog_irq) else $error("irq late");
  aux_rise_a: assert property ($rose(wd_expired[1]) && wd_enabled[1]
    |-> ##[0:1] auxiliary_reset_in) else $error("aux late");
  expiry_hold_a: assert property (!cmd_valid [*2] ##0 wd_expired[1]
    |=> wd_expired[1]) else $error("expiry dropped");
  timer_indep_a: assert property (cmd_valid && cmd_sel
    |=> ##1 $stable(wd_enabled[0])) else $error("timers coupled");
  cover property (interrupt_watchdog_irq);
  cover property (auxiliary_reset_in);
  cover property ($fell(wd_enabled[0]));
endmodule
bind dwdt_top dwdt_chk dwdt_chk_inst (
  .clk                    (clk),
  .resetn                 (resetn),
  .cmd_valid              (cmd_valid),
  .cmd_sel                (cmd_sel),
  .interrupt_watchdog_irq (interrupt_watchdog_irq),
  .auxiliary_reset_in     (auxiliary_reset_in),
  .module_reset_out_n     (module_reset_out_n),
  .wd_enabled             (wd_enabled),
  .wd_expired             (wd_expired)
);

// ==== dwdt_sw.sv ====
// software model: single writes on the command port
// assumes callers sit between clk edges
`timescale 1ns/10ps
module dwdt_sw (
  input  wire        clk,
  output reg         cmd_valid,
  output reg         cmd_sel,
  output reg  [31:0] cmd_wdata,
  output reg  [1:0]  cmd_code
);
  initial {cmd_valid, cmd_sel, cmd_wdata, cmd_code} = 36'h0;
  // one-cycle write; idle data inverted so stale words never match
  task wr(input s, input [1:0] c, input [31:0] d);
    begin
      @(posedge clk) #1;
      {cmd_valid, cmd_sel, cmd_code, cmd_wdata} = {1'b1, s, c, d};
      @(posedge clk) #1;
      {cmd_valid, cmd_wdata} = {1'b0, ~d};
    end
  endtask
endmodule

// ==== dual_watchdog_timers_tb.sv ====
// bench: command table, reset sources, reset defaults
// assumes dwdt_sw drives the command port
`timescale 1ns/10ps
`include "dwdt_map.vh"
module dual_watchdog_timers_tb;
  reg         clk, resetn;
  reg  [2:0]  src;
  reg  [14:0] rows [0:5];
  wire        vld, sel, irq, aux, rout_n;
  wire [31:0] wdata;
  wire [1:0]  code, en, ex;
  wire [31:0] obs = {25'h0, en, ex, irq, aux, rout_n};
  integer     err_total, tests_run, i;
  dwdt_sw dwdt_sw_inst (.clk(clk), .cmd_valid(vld), .cmd_sel(sel),
    .cmd_wdata(wdata), .cmd_code(code));
  dwdt_top dwdt_top_inst (.clk(clk), .resetn(resetn), .cmd_valid(vld),
    .cmd_sel(sel), .cmd_wdata(wdata), .cmd_code(code),
    .power_up_rst(src[0]), .debug_rst_n(~src[1]), .sw_module_rst(src[2]),
    .interrupt_watchdog_irq(irq), .auxiliary_reset_in(aux),
    .module_reset_out_n(rout_n), .wd_enabled(en), .wd_expired(ex));
  // expected port view from {enables, expiries}
  function [31:0] ev(input [3:0] v);
    ev = {25'h0, v, v[2] & v[0], v[1], ~v[1]};
  endfunction
  task chk(input [31:0] seen, input [31:0] want);
    begin
      tests_run = tests_run + 1;
      if (seen !== want) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task go(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task complete_run;
    begin
      if (err_total == 0 && tests_run > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard: the run needs about 5000 cycles
  initial begin
    #100000;
    err_total = err_total + 1;
    complete_run;
  end
  // rows: select, code, microseconds, state after 10 and 800 cycles
  initial begin
    {resetn, src, err_total, tests_run} = 0;
    rows[0] = {1'b0, 2'h1, 4'h2, 8'hcd};
    rows[1] = {1'b0, 2'h2, 4'h0, 8'hcd};
    rows[2] = {1'b1, 2'h1, 4'h1, 8'hdf};
    rows[3] = {1'b0, 2'h3, 4'h0, 8'haa};
    rows[4] = {1'b1, 2'h3, 4'h0, 8'h00};
    rows[5] = {1'b0, 2'h1, 4'h0, 8'h45}; // zero clamps to one tick
    go(16);
    resetn = 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      dwdt_sw_inst.wr(rows[i][14], 2'h0, `DWDT_KEY);
      dwdt_sw_inst.wr(rows[i][14], rows[i][13:12], {28'h0, rows[i][11:8]});
      go(10);
      chk(obs, ev(rows[i][7:4]));
      go(800);
      chk(obs, ev(rows[i][3:0]));
    end
    // lone load, then key with empty word, then unarmed load
    dwdt_sw_inst.wr(1'b1, 2'h1, 32'h3);
    dwdt_sw_inst.wr(1'b1, 2'h0, `DWDT_KEY);
    dwdt_sw_inst.wr(1'b1, 2'h0, 32'h0);
    dwdt_sw_inst.wr(1'b1, 2'h1, 32'h3);
    go(3);
    chk(obs, ev(4'h5));
    // over-range load clamps to 32 minutes of ticks
    dwdt_sw_inst.wr(1'b1, 2'h0, `DWDT_KEY);
    dwdt_sw_inst.wr(1'b1, 2'h1, 32'hffffffff);
    go(3);
    chk({1'b0, dwdt_top_inst.ldv_q[1]}, 32'h7270e000);
    for (i = 0; i < 3; i = i + 1) begin
      src = 3'h1 << i[1:0];
      go(5);
      chk({31'h0, rout_n}, 32'h0);
      src = 3'h0;
      go(5);
      chk({31'h0, rout_n}, 32'h1);
    end
    resetn = 1'b0;
    go(16);
    resetn = 1'b1;
    go(2);
    chk(obs, ev(4'hc));
    // eight and sixteen seconds in microsecond ticks
    chk({1'b0, dwdt_top_inst.cnt_q[0]}, 32'h007a1200);
    chk({1'b0, dwdt_top_inst.cnt_q[1]}, 32'h00f42400);
    complete_run;
  end
endmodule
